// ===== ffo_defines.vh
/*
 * Register map, fields and sizes of the flag offset block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef FFO_DEFINES_VH
`define FFO_DEFINES_VH

// =====================================================================
// apb register map (byte addresses)
`define FFO_ADDR_CFG        12'h000
`define FFO_ADDR_STATUS     12'h004
`define FFO_ADDR_EMPTY_OFS  12'h008
`define FFO_ADDR_FULL_OFS   12'h00c

// =====================================================================
// cfg register fields
`define FFO_CFG_IN_X18      0
`define FFO_CFG_OUT_X18     1
`define FFO_CFG_DEPTH_LO    2
`define FFO_CFG_DEPTH_HI    4
`define FFO_CFG_RESET       32'h0000_0000

// =====================================================================
// status register fields
`define FFO_ST_SERIAL       0
`define FFO_ST_AE_VALID     1
`define FFO_ST_AF_VALID     2
`define FFO_ST_WPTR_REG     3
`define FFO_ST_WPTR_WLO     4
`define FFO_ST_WPTR_WHI     5
`define FFO_ST_RPTR_REG     6
`define FFO_ST_RPTR_WLO     7
`define FFO_ST_RPTR_WHI     8
`define FFO_ST_SHCNT_LO     9
`define FFO_ST_SHCNT_HI     14

// =====================================================================
// sizing of the offset registers
`define FFO_OFS_W           17
`define FFO_OFS_BITS_X9     5'h0a
`define FFO_OFS_BITS_X18    5'h09
`define FFO_DEPTH_DEEPEST   3'h7
`define FFO_WORD_W          9
`define FFO_DATA_W          18
`define FFO_SYNC_W          26
`define FFO_FLAG_DELAY      2'h2

`endif

// ===== ffo_offset_prog.v
/*
 * Flag offset load, readback and flag validity for a FIFO, with APB status.
 * Assumes async pins and write/read clock pins well below pclk/2.
 */
// Overview of operation
// - with select and shift enable low, one serial bit per write edge, empty lsb first
// - nine-to-nine serial load is 20 bits, plus two per depth step, up to 34
// - any eighteen-bit port makes the serial load two bits shorter
// - serial load programs both offsets; flags invalid until all bits shifted
// - select low with shift enable high shifts nothing
// - serial load pauses on either control high and resumes with next bit
// - full flag valid two write edges, empty flag two read edges after completion
// - serial method gives no offset readback
// - nine-to-nine parallel load takes four writes, six for deepest option
// - other widths: two writes with eighteen-bit input, four with nine-bit
// - parallel writes fill empty lsb, msb, full lsb, msb then wrap
// - separate write and read offset pointers advance independently
// - master reset homes both pointers; partial reset leaves them
// - parallel load pauses via select or write strobe, resumes in order
// - in parallel mode a flag is invalid until its own offset is written
// - select and read strobe low put offset words on the data output
// - readback takes two reads x18 out, four x9, six deepest nine-to-nine
// - reads return empty words then full words then wrap
// - offset reads pause on strobe or select high and resume at saved pointer
// - an offset read overwrites the word held on the data output
// - offset readback works in standard and fall-through modes
// - loading method is latched only during master reset
// - partial reset keeps offsets and loading method
`timescale 1ns/10ps
`include "ffo_defines.vh"

module ffo_offset_prog (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        wclk_pin,
   input  wire        rclk_pin,
   input  wire        master_reset_n,
   input  wire        partial_reset_n,
   input  wire        serial_method_strap,
   input  wire        fall_through_mode,
   input  wire        offset_access_select_n,
   input  wire        serial_shift_enable_n,
   input  wire        write_strobe_n,
   input  wire        read_strobe_n,
   input  wire        serial_in,
   input  wire [17:0] data_in_bus,
   input  wire [17:0] fifo_rd_data,
   output wire [17:0] data_out_bus,
   output wire        data_out_is_offset,
   output wire        fifo_wr_pulse,
   output wire        fifo_rd_pulse,
   output wire        almost_empty_valid,
   output wire        almost_full_valid
);

   // =====================================================================
   // helpers
   // words per offset register: one at x18, two at x9, three for deepest x9/x9
   function [1:0] words_per_reg;
      input       port_x18;
      input       nine_nine;
      input [2:0] depth;
      begin
         if (port_x18) begin
            words_per_reg = 2'h1;
         end else if (nine_nine && depth == `FFO_DEPTH_DEEPEST) begin
            words_per_reg = 2'h3;
         end else begin
            words_per_reg = 2'h2;
         end
      end
   endfunction

   // =====================================================================
   // pin synchronisers; stage one feeds stage two only
   wire [`FFO_SYNC_W-1:0] pins_raw = {wclk_pin, rclk_pin, master_reset_n, partial_reset_n,
                                      serial_method_strap, offset_access_select_n,
                                      serial_shift_enable_n, write_strobe_n, read_strobe_n,
                                      serial_in, data_in_bus[15:0]};
   reg  [`FFO_SYNC_W-1:0] sync1_q;
   reg  [`FFO_SYNC_W-1:0] sync2_q;
   reg  [1:0]             din_hi1_q;
   reg  [1:0]             din_hi2_q;
   reg                    wclk_d1_q;
   reg                    rclk_d1_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q   <= {`FFO_SYNC_W{1'b0}};
         sync2_q   <= {`FFO_SYNC_W{1'b0}};
         din_hi1_q <= 2'h0;
         din_hi2_q <= 2'h0;
         wclk_d1_q <= 1'b0;
         rclk_d1_q <= 1'b0;
      end else begin
         sync1_q   <= pins_raw;
         sync2_q   <= sync1_q;
         din_hi1_q <= data_in_bus[17:16];
         din_hi2_q <= din_hi1_q;
         wclk_d1_q <= sync2_q[25];
         rclk_d1_q <= sync2_q[24];
      end
   end

   wire        s_wclk   = sync2_q[25];
   wire        s_rclk   = sync2_q[24];
   wire        s_mrs_n  = sync2_q[23];
   wire        s_prs_n  = sync2_q[22];
   wire        s_strap  = sync2_q[21];
   wire        s_sel_n  = sync2_q[20];
   wire        s_sen_n  = sync2_q[19];
   wire        s_wen_n  = sync2_q[18];
   wire        s_ren_n  = sync2_q[17];
   wire        s_si     = sync2_q[16];
   wire [17:0] s_din    = {din_hi2_q, sync2_q[15:0]};
   // write and read clock edges as one-cycle enables
   wire        wr_edge  = s_wclk & ~wclk_d1_q;
   wire        rd_edge  = s_rclk & ~rclk_d1_q;

   // =====================================================================
   // apb slave; answers one cycle after setup
   reg  [31:0] cfg_q;
   reg  [31:0] prdata_q;
   reg         pready_q;
   reg         pslverr_q;
   wire        apb_setup = psel & ~penable;
   wire        addr_ok   = (paddr == `FFO_ADDR_CFG) || (paddr == `FFO_ADDR_STATUS) ||
                           (paddr == `FFO_ADDR_EMPTY_OFS) || (paddr == `FFO_ADDR_FULL_OFS);
   wire        cfg_wr    = psel & penable & pready_q & pwrite & (paddr == `FFO_ADDR_CFG);
   reg  [31:0] rd_mux;

   // =====================================================================
   // active configuration, caught only while master reset is held
   reg         act_serial_q;
   reg         act_in_x18_q;
   reg         act_out_x18_q;
   reg  [2:0]  act_depth_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_serial_q  <= 1'b0;
         act_in_x18_q  <= 1'b0;
         act_out_x18_q <= 1'b0;
         act_depth_q   <= 3'h0;
      end else if (!s_mrs_n) begin
         act_serial_q  <= s_strap;
         act_in_x18_q  <= cfg_q[`FFO_CFG_IN_X18];
         act_out_x18_q <= cfg_q[`FFO_CFG_OUT_X18];
         act_depth_q   <= cfg_q[`FFO_CFG_DEPTH_HI:`FFO_CFG_DEPTH_LO];
      end
   end

   // sizes derived from the latched configuration
   wire        nine_nine = ~act_in_x18_q & ~act_out_x18_q;
   wire [4:0]  obits     = (nine_nine ? `FFO_OFS_BITS_X9 : `FFO_OFS_BITS_X18) + {2'h0, act_depth_q};
   wire [5:0]  sh_total  = {obits, 1'b0};
   wire [1:0]  wr_words  = words_per_reg(act_in_x18_q, nine_nine, act_depth_q);
   wire [1:0]  rd_words  = words_per_reg(act_out_x18_q, nine_nine, act_depth_q);
   wire [`FFO_OFS_W-1:0] ofs_mask = ~({`FFO_OFS_W{1'b1}} << obits);

   // =====================================================================
   // offset registers, write pointer and serial counter
   reg  [`FFO_OFS_W-1:0] empty_ofs_q;
   reg  [`FFO_OFS_W-1:0] full_ofs_q;
   reg                   wptr_reg_q;
   reg  [1:0]            wptr_word_q;
   reg  [5:0]            sh_cnt_q;
   reg                   ae_valid_q;
   reg                   af_valid_q;
   reg  [1:0]            af_wait_q;
   reg                   ae_req_q;
   reg                   fifo_wr_q;

   wire        ser_shift = wr_edge & act_serial_q & ~s_sel_n & ~s_sen_n;
   wire        par_write = wr_edge & ~act_serial_q & ~s_sel_n & ~s_wen_n;
   wire        ser_last  = (sh_cnt_q == sh_total - 6'h1);
   wire        par_last  = (wptr_word_q == wr_words - 2'h1);
   wire [5:0]  sh_full   = sh_cnt_q - {1'b0, obits};
   // parallel word merged into its slice; x9 input fills nine bits per word
   wire [26:0] word_sh   = {18'h0, s_din[8:0]} << (wptr_word_q * `FFO_WORD_W);
   wire [26:0] keep_sh   = ~({18'h0, 9'h1ff} << (wptr_word_q * `FFO_WORD_W));
   wire [`FFO_OFS_W-1:0] cur_ofs  = wptr_reg_q ? full_ofs_q : empty_ofs_q;
   wire [`FFO_OFS_W-1:0] par_val  = act_in_x18_q ? s_din[`FFO_OFS_W-1:0] :
                                    ((cur_ofs & keep_sh[`FFO_OFS_W-1:0]) | word_sh[`FFO_OFS_W-1:0]);

   // master reset homes pointers; partial reset leaves every field here alone
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         empty_ofs_q <= {`FFO_OFS_W{1'b0}};
         full_ofs_q  <= {`FFO_OFS_W{1'b0}};
         wptr_reg_q  <= 1'b0;
         wptr_word_q <= 2'h0;
         sh_cnt_q    <= 6'h0;
         af_valid_q  <= 1'b0;
         af_wait_q   <= 2'h0;
         ae_req_q    <= 1'b0;
         fifo_wr_q   <= 1'b0;
      end else if (!s_mrs_n) begin
         empty_ofs_q <= {`FFO_OFS_W{1'b0}};
         full_ofs_q  <= {`FFO_OFS_W{1'b0}};
         wptr_reg_q  <= 1'b0;
         wptr_word_q <= 2'h0;
         sh_cnt_q    <= 6'h0;
         af_valid_q  <= 1'b0;
         af_wait_q   <= 2'h0;
         ae_req_q    <= 1'b0;
         fifo_wr_q   <= 1'b0;
      end else begin
         fifo_wr_q <= wr_edge & s_sel_n & ~s_wen_n;
         // full flag countdown in write edges after its offset completes
         if (wr_edge && af_wait_q != 2'h0) begin
            af_wait_q <= af_wait_q - 2'h1;
            if (af_wait_q == 2'h1) begin
               af_valid_q <= 1'b1;
            end
         end
         if (ser_shift) begin
            // a fresh complete set is needed; whole set is reloaded each time
            af_valid_q <= 1'b0;
            af_wait_q  <= 2'h0;
            if (sh_cnt_q < {1'b0, obits}) begin
               empty_ofs_q[sh_cnt_q[4:0]] <= s_si;
            end else begin
               full_ofs_q[sh_full[4:0]] <= s_si;
            end
            if (ser_last) begin
               sh_cnt_q  <= 6'h0;
               af_wait_q <= `FFO_FLAG_DELAY;
               ae_req_q  <= ~ae_req_q;
            end else begin
               sh_cnt_q <= sh_cnt_q + 6'h1;
            end
         end else if (par_write) begin
            if (wptr_reg_q) begin
               full_ofs_q <= par_val & ofs_mask;
               af_valid_q <= 1'b0;
               af_wait_q  <= par_last ? `FFO_FLAG_DELAY : 2'h0;
            end else begin
               empty_ofs_q <= par_val & ofs_mask;
               ae_req_q    <= par_last ? ~ae_req_q : ae_req_q;
            end
            if (par_last) begin
               wptr_word_q <= 2'h0;
               wptr_reg_q  <= ~wptr_reg_q;
            end else begin
               wptr_word_q <= wptr_word_q + 2'h1;
            end
         end
      end
   end

   // =====================================================================
   // empty flag tracking on read edges; write side hands over by toggle
   reg        ae_ack_q;
   reg  [1:0] ae_wait_q;
   wire       ae_start  = ae_req_q ^ ae_ack_q;
   // a serial bit or a parallel empty word drops the empty flag at once
   wire       ae_kill   = ser_shift | (par_write & ~wptr_reg_q);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ae_ack_q   <= 1'b0;
         ae_wait_q  <= 2'h0;
         ae_valid_q <= 1'b0;
      end else if (!s_mrs_n) begin
         ae_ack_q   <= 1'b0;
         ae_wait_q  <= 2'h0;
         ae_valid_q <= 1'b0;
      end else begin
         if (ae_kill) begin
            ae_valid_q <= 1'b0;
            ae_wait_q  <= 2'h0;
         end
         if (ae_start) begin
            ae_ack_q  <= ae_req_q;
            ae_wait_q <= `FFO_FLAG_DELAY;
         end else if (rd_edge && ae_wait_q != 2'h0 && !ae_kill) begin
            ae_wait_q <= ae_wait_q - 2'h1;
            if (ae_wait_q == 2'h1) begin
               ae_valid_q <= 1'b1;
            end
         end
      end
   end

   // =====================================================================
   // offset readback on the data output, own read pointer
   reg                   rptr_reg_q;
   reg  [1:0]            rptr_word_q;
   reg  [17:0]           dout_q;
   reg                   dout_ofs_q;
   reg                   fifo_rd_q;
   // serial method offers no readback, so such reads are ignored
   wire       ofs_read  = rd_edge & ~act_serial_q & ~s_sel_n & ~s_ren_n;
   wire       rd_last   = (rptr_word_q == rd_words - 2'h1);
   wire [`FFO_OFS_W-1:0] rd_ofs  = rptr_reg_q ? full_ofs_q : empty_ofs_q;
   wire [26:0] rd_sh    = {10'h0, rd_ofs} >> (rptr_word_q * `FFO_WORD_W);
   wire [17:0] rd_word  = act_out_x18_q ? {1'b0, rd_ofs} : {9'h0, rd_sh[8:0]};
   wire       fifo_rd   = rd_edge & s_sel_n & ~s_ren_n;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rptr_reg_q  <= 1'b0;
         rptr_word_q <= 2'h0;
         dout_q      <= 18'h0;
         dout_ofs_q  <= 1'b0;
         fifo_rd_q   <= 1'b0;
      end else if (!s_mrs_n || !s_prs_n) begin
         // both resets clear the output register; only master homes the pointer
         if (!s_mrs_n) begin
            rptr_reg_q  <= 1'b0;
            rptr_word_q <= 2'h0;
         end
         dout_q     <= 18'h0;
         dout_ofs_q <= 1'b0;
         fifo_rd_q  <= 1'b0;
      end else begin
         fifo_rd_q <= fifo_rd;
         if (ofs_read) begin
            dout_q     <= rd_word;
            dout_ofs_q <= 1'b1;
            if (rd_last) begin
               rptr_word_q <= 2'h0;
               rptr_reg_q  <= ~rptr_reg_q;
            end else begin
               rptr_word_q <= rptr_word_q + 2'h1;
            end
         end else if (fifo_rd) begin
            dout_q     <= fifo_rd_data;
            dout_ofs_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // apb read mux and register writes
   always @* begin
      rd_mux = 32'h0;
      case (paddr)
         `FFO_ADDR_CFG:       rd_mux = cfg_q;
         `FFO_ADDR_STATUS: begin
            rd_mux[`FFO_ST_SERIAL]                    = act_serial_q;
            rd_mux[`FFO_ST_AE_VALID]                  = ae_valid_q;
            rd_mux[`FFO_ST_AF_VALID]                  = af_valid_q;
            rd_mux[`FFO_ST_WPTR_REG]                  = wptr_reg_q;
            rd_mux[`FFO_ST_WPTR_WHI:`FFO_ST_WPTR_WLO] = wptr_word_q;
            rd_mux[`FFO_ST_RPTR_REG]                  = rptr_reg_q;
            rd_mux[`FFO_ST_RPTR_WHI:`FFO_ST_RPTR_WLO] = rptr_word_q;
            rd_mux[`FFO_ST_SHCNT_HI:`FFO_ST_SHCNT_LO] = sh_cnt_q;
         end
         `FFO_ADDR_EMPTY_OFS: rd_mux = {15'h0, act_serial_q ? {`FFO_OFS_W{1'b0}} : empty_ofs_q};
         `FFO_ADDR_FULL_OFS:  rd_mux = {15'h0, act_serial_q ? {`FFO_OFS_W{1'b0}} : full_ofs_q};
         default:             rd_mux = 32'h0;
      endcase
   end

   // answer lands in the access cycle; cfg is not touched by partial reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q     <= `FFO_CFG_RESET;
         prdata_q  <= 32'h0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= apb_setup;
         pslverr_q <= apb_setup & ~addr_ok;
         prdata_q  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
         if (cfg_wr) begin
            cfg_q <= {27'h0, pwdata[`FFO_CFG_DEPTH_HI:0]};
         end
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign data_out_bus       = dout_q;
   assign data_out_is_offset = dout_ofs_q;
   assign fifo_wr_pulse      = fifo_wr_q;
   assign fifo_rd_pulse      = fifo_rd_q;
   assign almost_empty_valid = ae_valid_q;
   assign almost_full_valid  = af_valid_q;

endmodule

// ===== ffo_host_model.sv
/* host model: drives the fifo write and read pins of the offset block.
   assumes pclk from the bench; each pin edge has 4 pclk setup and hold. */
`timescale 1ns/10ps
module ffo_host_model (
   input  wire         pclk,
   output logic        wclk_pin,
   output logic        rclk_pin,
   output logic        master_reset_n,
   output logic        partial_reset_n,
   output logic        serial_method_strap,
   output logic        fall_through_mode,
   output logic        offset_access_select_n,
   output logic        serial_shift_enable_n,
   output logic        write_strobe_n,
   output logic        read_strobe_n,
   output logic        serial_in,
   output logic [17:0] data_in_bus,
   output logic [17:0] fifo_rd_data
);
   // =====================================
   // idle levels: no operation, no reset
   initial begin
      {wclk_pin, rclk_pin, fall_through_mode, serial_method_strap} = 4'h0;
      {master_reset_n, partial_reset_n, offset_access_select_n, serial_shift_enable_n} = 4'hf;
      {write_strobe_n, read_strobe_n, serial_in} = 3'h6;
      {data_in_bus, fifo_rd_data} = 36'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one write edge, c = {select, shift enable, write strobe, serial bit}
   task automatic wedge(input logic [3:0] c, input logic [17:0] d);
      @(posedge pclk);
      {offset_access_select_n, serial_shift_enable_n, write_strobe_n, serial_in, data_in_bus} <= {c, d};
      tick(4);
      wclk_pin <= 1'b1;
      tick(4);
      wclk_pin <= 1'b0;
      tick(4);
      // strobes dropped so a later read edge never meets a write
      {write_strobe_n, serial_shift_enable_n, data_in_bus} <= {2'b11, ~d};
   endtask
   // one read edge, c = {select, read strobe}, m = memory word
   task automatic redge(input logic [1:0] c, input logic [17:0] m);
      @(posedge pclk);
      {offset_access_select_n, read_strobe_n, fifo_rd_data} <= {c, m};
      tick(4);
      rclk_pin <= 1'b1;
      tick(4);
      rclk_pin <= 1'b0;
      tick(4);
      {read_strobe_n, fifo_rd_data} <= {1'b1, ~m};
   endtask
   // method strap held across the whole master reset
   task automatic mreset(input logic strap);
      @(posedge pclk);
      {serial_method_strap, master_reset_n} <= {strap, 1'b0};
      tick(8);
      master_reset_n <= 1'b1;
      tick(6);
   endtask
   task automatic preset();
      @(posedge pclk);
      partial_reset_n <= 1'b0;
      tick(8);
      partial_reset_n <= 1'b1;
      tick(6);
   endtask
endmodule

// ===== ffo_offset_prog_asserts.sv
/* assertions on the apb and pin ports of the flag offset block.
   assumes one pclk domain, presetn async; pins held 4 pclk round edges. */
`timescale 1ns/10ps
module ffo_asserts (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [11:0] paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        master_reset_n,
   input wire        partial_reset_n,
   input wire        serial_method_strap,
   input wire        offset_access_select_n,
   input wire        read_strobe_n,
   input wire        data_out_is_offset,
   input wire        fifo_wr_pulse,
   input wire        fifo_rd_pulse,
   input wire        almost_empty_valid,
   input wire        almost_full_valid
);
   logic ser_q;
   // =====================================
   // loading method, only taken in master reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ser_q <= 1'b0;
      else if (!master_reset_n) ser_q <= serial_method_strap;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================
   // properties
   property p_ready_next; psel && !penable |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
   property p_ready_qual; pready |-> psel && penable; endproperty
   a_ready_qual: assert property (p_ready_qual) else $error("pready outside access");
   property p_err_unmap; psel && !penable && paddr > 12'h00c |=> pslverr && pready; endproperty
   a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");
   property p_wr_route; fifo_wr_pulse |-> offset_access_select_n; endproperty
   a_wr_route: assert property (p_wr_route) else $error("memory write with select low");
   property p_rd_route; fifo_rd_pulse |-> offset_access_select_n; endproperty
   a_rd_route: assert property (p_rd_route) else $error("memory read with select low");
   property p_ofs_src; $rose(data_out_is_offset) |-> !offset_access_select_n && !read_strobe_n; endproperty
   a_ofs_src: assert property (p_ofs_src) else $error("offset word without offset read");
   property p_no_ser_rd; $rose(data_out_is_offset) |-> !ser_q; endproperty
   a_no_ser_rd: assert property (p_no_ser_rd) else $error("offset readback in serial method");
   property p_mrs_flags; !master_reset_n [*6] |-> !almost_full_valid && !almost_empty_valid; endproperty
   a_mrs_flags: assert property (p_mrs_flags) else $error("flag valid in master reset");
   property p_prs_keep; !partial_reset_n && master_reset_n |=> $stable(almost_full_valid) && $stable(almost_empty_valid); endproperty
   a_prs_keep: assert property (p_prs_keep) else $error("partial reset moved a flag");
endmodule

bind ffo_offset_prog ffo_asserts u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
   .master_reset_n, .partial_reset_n, .serial_method_strap, .offset_access_select_n, .read_strobe_n,
   .data_out_is_offset, .fifo_wr_pulse, .fifo_rd_pulse, .almost_empty_valid, .almost_full_valid);

// ===== tb_fifo_flag_offset_programming.sv
/* self-checking bench for the flag offset block: apb master, host pin model.
   assumes the design and its defines header are compiled alongside. */
`timescale 1ns/10ps
`include "ffo_defines.vh"
module tb_fifo_flag_offset_programming;
   localparam logic [15:0] E = 16'hb5a3, F = 16'h4c7e;
   localparam logic [3:0]  W_PAR = 4'h5, W_MEM = 4'hd, W_NOP = 4'he, W_HLD = 4'h6;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   int          error_cnt = 0, samples_checked = 0;
   wire         wclk_pin, rclk_pin, master_reset_n, partial_reset_n, serial_method_strap, fall_through_mode;
   wire         offset_access_select_n, serial_shift_enable_n, write_strobe_n, read_strobe_n, serial_in;
   wire [17:0]  data_in_bus, fifo_rd_data, data_out_bus;
   wire [31:0]  prdata;
   wire         pready, pslverr, data_out_is_offset, fifo_wr_pulse, fifo_rd_pulse, almost_empty_valid, almost_full_valid;
   always #4 pclk = ~pclk;
   ffo_host_model host (.*);
   ffo_offset_prog DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .wclk_pin, .rclk_pin, .master_reset_n, .partial_reset_n, .serial_method_strap, .fall_through_mode,
      .offset_access_select_n, .serial_shift_enable_n, .write_strobe_n, .read_strobe_n, .serial_in,
      .data_in_bus, .fifo_rd_data, .data_out_bus, .data_out_is_offset, .fifo_wr_pulse, .fifo_rd_pulse,
      .almost_empty_valid, .almost_full_valid);
   // =====================================
   // shared tasks
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         results();
      end else begin
         rd = prdata;
         er = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   // =====================================
   // scenarios
   task automatic t_reset();
      apb(1'b0, `FFO_ADDR_CFG, 32'h0);
      chk(rd, `FFO_CFG_RESET);
      apb(1'b1, 12'h010, 32'h5a5a);
      chk(er, 1'b1);
      apb(1'b0, 12'h010, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
   endtask
   // x9 in, x18 out, deepest: two words per offset, pauses midway
   task automatic t_par();
      logic [15:0] w;
      apb(1'b1, `FFO_ADDR_CFG, 32'h1e);
      host.mreset(1'b0);
      for (int i = 0; i < 4; i++) begin
         w = (i < 2) ? E : F;
         host.wedge(W_PAR, i[0] ? {11'h0, w[15:9]} : {9'h0, w[8:0]});
         if (i == 1) begin
            host.redge(2'b11, 18'h0);
            chk(almost_empty_valid, 1'b0);
            host.redge(2'b11, 18'h0);
            chk(almost_empty_valid, 1'b1);
            chk(almost_full_valid, 1'b0);
            host.wedge(W_MEM, 18'h3ffff);
            host.wedge(W_HLD, 18'h3ffff);
         end
      end
      host.wedge(W_NOP, 18'h0);
      chk(almost_full_valid, 1'b0);
      host.wedge(W_NOP, 18'h0);
      chk(almost_full_valid, 1'b1);
      apb(1'b0, `FFO_ADDR_EMPTY_OFS, 32'h0);
      chk(rd, {16'h0, E});
      apb(1'b0, `FFO_ADDR_FULL_OFS, 32'h0);
      chk(rd, {16'h0, F});
      host.fall_through_mode <= 1'b1;
      host.redge(2'b00, 18'h0);
      chk({data_out_is_offset, data_out_bus}, {14'h1, 2'h0, E});
      host.redge(2'b10, 18'h2d2d1);
      chk({data_out_is_offset, data_out_bus}, 32'h2d2d1);
      host.redge(2'b00, 18'h0);
      chk({data_out_is_offset, data_out_bus}, {14'h1, 2'h0, F});
      host.redge(2'b00, 18'h0);
      chk(data_out_bus, {16'h0, E});
      host.preset();
      chk(data_out_is_offset, 1'b0);
      chk({almost_full_valid, almost_empty_valid}, 2'b11);
      host.redge(2'b00, 18'h0);
      chk(data_out_bus, {16'h0, F});
   endtask
   // x9 to x9, shallowest: 20 bits with pauses before the last
   task automatic t_ser();
      logic [19:0] v;
      v = {10'h0ca, 10'h2b5};
      apb(1'b1, `FFO_ADDR_CFG, 32'h0);
      host.mreset(1'b1);
      host.serial_method_strap <= 1'b0;
      apb(1'b0, `FFO_ADDR_STATUS, 32'h0);
      chk(rd[`FFO_ST_SERIAL], 1'b1);
      for (int i = 0; i < 20; i++) begin
         if (i == 10) begin
            host.wedge(W_HLD, 18'h0);
            host.wedge(W_MEM, 18'h0);
         end
         if (i == 19) begin
            repeat (2) host.wedge(W_NOP, 18'h0);
            chk(almost_full_valid, 1'b0);
         end
         host.wedge({3'b001, v[i]}, 18'h0);
      end
      repeat (2) host.wedge(W_NOP, 18'h0);
      chk(almost_full_valid, 1'b1);
      repeat (2) host.redge(2'b11, 18'h0);
      chk(almost_empty_valid, 1'b1);
      host.redge(2'b00, 18'h0);
      chk(data_out_is_offset, 1'b0);
      apb(1'b0, `FFO_ADDR_EMPTY_OFS, 32'h0);
      chk(rd, 32'h0);
   endtask
   // =====================================
   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_par();
      t_ser();
      results();
   end
endmodule
